// ---- dfhi_pkg.sv ----
package dfhi_pkg;

  localparam int unsigned DATA_W      = 8;     // host data path
  localparam int unsigned ADDR_W      = 16;    // generated address
  localparam int unsigned WORD_W      = 16;    // wide host bus word
  localparam int unsigned SYNC_W      = 7;     // synchronised control pins

  // positions of control pins in the synchroniser vector
  localparam int unsigned PIN_CE      = 0;
  localparam int unsigned PIN_IO_REQ  = 1;
  localparam int unsigned PIN_RD      = 2;
  localparam int unsigned PIN_WR      = 3;
  localparam int unsigned PIN_FETCH   = 4;
  localparam int unsigned PIN_PRIO    = 5;
  localparam int unsigned PIN_GRANT   = 6;

  // return-from-interrupt byte pair
  localparam logic [7:0] RETURN_BYTE0 = 8'hED;
  localparam logic [7:0] RETURN_BYTE1 = 8'h4D;

  // command bytes
  localparam logic [7:0] CMD_RESET_DISABLE_INT = 8'hF1;
  localparam logic [7:0] CMD_LOAD_VECTOR       = 8'hF2;
  localparam logic [7:0] CMD_LOAD_MATCH        = 8'hF3;
  localparam logic [7:0] CMD_LOAD_ADDRESS      = 8'hF4;
  localparam logic [7:0] CMD_ENABLE_INT        = 8'hF5;
  localparam logic [7:0] CMD_LANE_UPPER        = 8'hF6;
  localparam logic [7:0] CMD_LANE_LOWER        = 8'hF7;

  // reset values
  localparam logic [7:0]  VECTOR_RST  = 8'h00;
  localparam logic [7:0]  MATCH_RST   = 8'h00;
  localparam logic [15:0] ADDRESS_RST = 16'h0000;

  // status byte fields
  localparam int unsigned ST_PENDING  = 0;
  localparam int unsigned ST_SERVICE  = 1;
  localparam int unsigned ST_INT_EN   = 2;
  localparam int unsigned ST_MATCH    = 3;
  localparam int unsigned ST_LANE     = 4;
  localparam int unsigned ST_GRANTED  = 5;

  typedef enum logic [4:0] {
    ARG_NONE    = 5'b00001,
    ARG_VECTOR  = 5'b00010,
    ARG_MATCH   = 5'b00100,
    ARG_ADDR_LO = 5'b01000,
    ARG_ADDR_HI = 5'b10000
  } dfhi_arg_e;

endpackage : dfhi_pkg

// ---- dfhi_host_interface.sv ----
// Operation
// - controller uses 8-bit data, 16-bit addresses and full byte compares
// - on 16-bit buses matching compares one selected byte lane only
// - fetch marker, I/O request and priority-in active: drive vector byte while pending or in service
// - I/O request qualifies host accesses and signals own I/O cycles
// - fetched byte pair ED then 4D ends interrupt service
// - reset-and-disable-interrupts command ends interrupt state
// - status driven from second edge of held read access
`timescale 1ns/100ps
`default_nettype none

module dfhi_host_interface (
  input  wire logic        mclk,             // 250 MHz clock
  input  wire logic        nrst,             // async reset, active low
  input  wire logic        chip_enable_n,    // pin: chip enable
  input  wire logic        io_request_n_in,  // pin: I/O request, input side
  input  wire logic        read_n,           // pin: read strobe
  input  wire logic        write_n,          // pin: write strobe
  input  wire logic        fetch_marker_n,   // pin: instruction fetch marker
  input  wire logic        priority_in,      // pin: daisy chain in
  input  wire logic        bus_grant_n,      // pin: bus granted
  input  wire logic [7:0]  data_in,          // pin: data bus input
  input  wire logic        engine_bus_req,   // engine wants the bus
  input  wire logic        engine_io_cycle,  // engine runs an I/O cycle
  input  wire logic        irq_event,        // engine interrupt event
  input  wire logic        search_valid,     // search word valid
  input  wire logic [15:0] search_word,      // word from wide bus
  output logic [7:0]       data_out,         // data bus output
  output logic             data_oe,          // data bus enable
  output logic             io_request_n_out, // I/O request drive level
  output logic             io_request_oe,    // I/O request enable
  output logic             bus_request_n,    // bus request
  output logic             interrupt_n,      // interrupt request
  output logic             priority_out,     // daisy chain out
  output logic [15:0]      address_out,      // generated address
  output logic             match_found       // byte match pulse
);

  logic [dfhi_pkg::SYNC_W-1:0] pin_s1;
  logic [dfhi_pkg::SYNC_W-1:0] pin_s2;
  logic [7:0]                  data_s1;
  logic [7:0]                  data_s2;
  logic                        wr_prev;
  logic                        fetch_prev;
  logic                        rd_hold;
  logic                        return_half;
  logic                        pending;
  logic                        in_service;
  logic                        int_en;
  logic                        lane_upper;
  logic [7:0]                  vector;
  logic [7:0]                  match_byte;
  dfhi_pkg::dfhi_arg_e         arg;
  logic [7:0]                  status_byte;
  logic                        acc, wr_take, read_active, ack_active, fetch_take;
  logic                        return_done, cmd_reset, addr_load;
  logic [7:0]                  lane_byte;

  // two flops on every pin before use
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1  <= 7'h7F;
      pin_s2  <= 7'h7F;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
    end else begin
      pin_s1  <= {bus_grant_n, ~priority_in, fetch_marker_n, write_n, read_n,
                  io_request_n_in, chip_enable_n};
      pin_s2  <= pin_s1;
      data_s1 <= data_in;
      data_s2 <= data_s1;
    end
  end

  // all pin bits active low after the inversion of priority_in
  always_comb begin
    acc         = !pin_s2[dfhi_pkg::PIN_CE] && !pin_s2[dfhi_pkg::PIN_IO_REQ];
    wr_take     = acc && !pin_s2[dfhi_pkg::PIN_WR] && wr_prev;
    read_active = acc && !pin_s2[dfhi_pkg::PIN_RD] && pin_s2[dfhi_pkg::PIN_FETCH];
    ack_active  = !pin_s2[dfhi_pkg::PIN_FETCH] && !pin_s2[dfhi_pkg::PIN_IO_REQ]
                  && !pin_s2[dfhi_pkg::PIN_PRIO];
    fetch_take  = !pin_s2[dfhi_pkg::PIN_FETCH] && pin_s2[dfhi_pkg::PIN_IO_REQ] && fetch_prev;
    return_done = fetch_take && return_half && (data_s2 == dfhi_pkg::RETURN_BYTE1);
    cmd_reset   = wr_take && (arg == dfhi_pkg::ARG_NONE)
                  && (data_s2 == dfhi_pkg::CMD_RESET_DISABLE_INT);
    addr_load   = wr_take && ((arg == dfhi_pkg::ARG_ADDR_LO) || (arg == dfhi_pkg::ARG_ADDR_HI));
    lane_byte   = lane_upper ? search_word[15:8] : search_word[7:0];
    status_byte = 8'h00;
    status_byte[dfhi_pkg::ST_PENDING] = pending;
    status_byte[dfhi_pkg::ST_SERVICE] = in_service;
    status_byte[dfhi_pkg::ST_INT_EN]  = int_en;
    status_byte[dfhi_pkg::ST_MATCH]   = match_found;
    status_byte[dfhi_pkg::ST_LANE]    = lane_upper;
    status_byte[dfhi_pkg::ST_GRANTED] = !pin_s2[dfhi_pkg::PIN_GRANT];
  end

  // edge history of the sampled strobes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_prev    <= 1'b1;
      fetch_prev <= 1'b1;
      rd_hold    <= 1'b0;
    end else begin
      wr_prev    <= pin_s2[dfhi_pkg::PIN_WR] || !acc;
      fetch_prev <= pin_s2[dfhi_pkg::PIN_FETCH];
      rd_hold    <= read_active;
    end
  end

  // command decoder with argument bytes
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      arg        <= dfhi_pkg::ARG_NONE;
      vector     <= dfhi_pkg::VECTOR_RST;
      match_byte <= dfhi_pkg::MATCH_RST;
      lane_upper <= 1'b0;
    end else if (wr_take) begin
      case (arg)
        dfhi_pkg::ARG_NONE: begin
          case (data_s2)
            dfhi_pkg::CMD_LOAD_VECTOR:  arg <= dfhi_pkg::ARG_VECTOR;
            dfhi_pkg::CMD_LOAD_MATCH:   arg <= dfhi_pkg::ARG_MATCH;
            dfhi_pkg::CMD_LOAD_ADDRESS: arg <= dfhi_pkg::ARG_ADDR_LO;
            dfhi_pkg::CMD_LANE_UPPER:   lane_upper <= 1'b1;
            dfhi_pkg::CMD_LANE_LOWER:   lane_upper <= 1'b0;
            default:                    arg <= dfhi_pkg::ARG_NONE;
          endcase
        end
        dfhi_pkg::ARG_VECTOR: begin
          vector <= data_s2;
          arg    <= dfhi_pkg::ARG_NONE;
        end
        dfhi_pkg::ARG_MATCH: begin
          match_byte <= data_s2;
          arg        <= dfhi_pkg::ARG_NONE;
        end
        dfhi_pkg::ARG_ADDR_LO: arg <= dfhi_pkg::ARG_ADDR_HI;
        default:               arg <= dfhi_pkg::ARG_NONE;
      endcase
    end
  end

  // 16-bit address counter and byte compare
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      address_out <= dfhi_pkg::ADDRESS_RST;
      match_found <= 1'b0;
    end else begin
      if (addr_load && arg == dfhi_pkg::ARG_ADDR_LO) begin
        address_out[7:0] <= data_s2;
      end else if (addr_load) begin
        address_out[15:8] <= data_s2;
      end else if (search_valid) begin
        address_out <= address_out + 16'h0001;
      end
      match_found <= search_valid && (lane_byte == match_byte);
    end
  end

  // interrupt state; a new event wins over the acknowledge clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pending     <= 1'b0;
      in_service  <= 1'b0;
      int_en      <= 1'b0;
      return_half <= 1'b0;
    end else begin
      if (cmd_reset) begin
        int_en <= 1'b0;
      end else if (wr_take && arg == dfhi_pkg::ARG_NONE
                   && data_s2 == dfhi_pkg::CMD_ENABLE_INT) begin
        int_en <= 1'b1;
      end
      if (cmd_reset) begin
        pending <= 1'b0;
      end else if (irq_event && int_en) begin
        pending <= 1'b1;
      end else if (ack_active) begin
        pending <= 1'b0;
      end
      if (ack_active && pending) begin
        in_service <= 1'b1;
      end else if (cmd_reset || return_done) begin
        in_service <= 1'b0;
      end
      if (fetch_take) begin
        return_half <= (data_s2 == dfhi_pkg::RETURN_BYTE0);
      end
    end
  end

  // pin drivers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_out         <= 8'h00;
      data_oe          <= 1'b0;
      io_request_n_out <= 1'b1;
      io_request_oe    <= 1'b0;
      bus_request_n    <= 1'b1;
      interrupt_n      <= 1'b1;
      priority_out     <= 1'b0;
    end else begin
      data_oe          <= (ack_active && (pending || in_service)) || (read_active && rd_hold);
      data_out         <= ack_active ? vector : status_byte;
      io_request_oe    <= !pin_s2[dfhi_pkg::PIN_GRANT] && engine_io_cycle;
      io_request_n_out <= !engine_io_cycle;
      bus_request_n    <= !engine_bus_req;
      interrupt_n      <= !pending;
      priority_out     <= !pin_s2[dfhi_pkg::PIN_PRIO] && !pending && !in_service;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  property p_vector;
    ack_active && pending |=> data_oe && (data_out == $past(vector));
  endproperty
  a_vector: assert property (p_vector) else $error("vector not driven");

  property p_status;
    read_active && rd_hold |=> data_oe && (data_out == $past(status_byte));
  endproperty
  a_status: assert property (p_status) else $error("status not driven");

  property p_no_early;
    read_active && !rd_hold && !ack_active |=> !data_oe;
  endproperty
  a_no_early: assert property (p_no_early) else $error("status driven early");

  property p_return;
    return_done && !(ack_active && pending) |=> !in_service;
  endproperty
  a_return: assert property (p_return) else $error("return not honoured");

  property p_reset_cmd;
    cmd_reset && !(ack_active && pending) |=> !in_service && !pending ##1 interrupt_n;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command ignored");

  property p_lane;
    search_valid |=> match_found == ($past(lane_upper) ? ($past(search_word[15:8]) ==
                     $past(match_byte)) : ($past(search_word[7:0]) == $past(match_byte)));
  endproperty
  a_lane: assert property (p_lane) else $error("lane compare wrong");

  property p_address;
    search_valid && !addr_load |=> address_out == 16'($past(address_out) + 16'h0001);
  endproperty
  a_address: assert property (p_address) else $error("address step wrong");

  property p_io_drive;
    io_request_oe |-> !io_request_n_out && $past(!pin_s2[dfhi_pkg::PIN_GRANT]);
  endproperty
  a_io_drive: assert property (p_io_drive) else $error("I/O request misdriven");

endmodule : dfhi_host_interface

`default_nettype wire

// ---- dfhi_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dfhi_host_model (
  input  wire logic       mclk,           // clock
  input  wire logic       bus_request_n,  // controller wants bus
  input  wire logic [7:0] data_out,       // controller data
  input  wire logic       data_oe,        // controller drives data
  input  wire logic       io_req_n_out,   // controller I/O request
  input  wire logic       io_req_oe,      // controller drives I/O request
  output logic            chip_enable_n,  // select
  output logic            io_request_n,   // I/O request wire
  output logic            read_n,         // read strobe
  output logic            write_n,        // write strobe
  output logic            fetch_marker_n, // fetch marker
  output logic            priority_in,    // chain in
  output logic            bus_grant_n,    // grant
  output logic [7:0]      data_bus        // data wire
);
  logic       host_io_req_n;
  logic       host_drv;
  logic [7:0] host_data;
  logic [1:0] host_hold_grant;
  logic [3:0] page_reg;

  initial begin
    {chip_enable_n, host_io_req_n, read_n, write_n, fetch_marker_n} = 5'h1F;
    host_drv = 1'b0;
    host_data = 8'h5A;
    host_hold_grant = 2'b00;
  end
  // glue: active-high hold grant, inverted, two cycles late
  always @(negedge mclk) host_hold_grant <= {host_hold_grant[0], !bus_request_n};
  assign bus_grant_n  = !host_hold_grant[1];
  assign priority_in  = 1'b1;
  // host strobe floats to pull-up while granted
  assign io_request_n = io_req_oe ? io_req_n_out : (host_hold_grant[1] | host_io_req_n);
  assign data_bus     = data_oe ? data_out : (host_drv ? host_data : ~host_data);
  // page bits latched while controller idle, held while it requests the bus
  always @(negedge mclk) if (bus_request_n) page_reg <= host_data[3:0];

  // lines: ce, ioreq, rd, wr, fetch, all active low
  task automatic host_cycle(input logic [4:0] lines, input logic [7:0] d, input int hold);
    @(negedge mclk);
    {chip_enable_n, host_io_req_n, read_n, write_n, fetch_marker_n} = lines;
    host_data = d;
    host_drv = !lines[1] || (!lines[0] && lines[3]);
    repeat (hold) @(negedge mclk);
    {chip_enable_n, host_io_req_n, read_n, write_n, fetch_marker_n} = 5'h1F;
    host_drv = 1'b0;
    repeat (4) @(negedge mclk);
  endtask : host_cycle
endmodule : dfhi_host_model
`default_nettype wire

// ---- test_dma_foreign_host_interface.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_dma_foreign_host_interface;
  logic        mclk, nrst, engine_bus_req, engine_io_cycle, irq_event, search_valid;
  logic [15:0] search_word, address_out, a, ed;
  logic [7:0]  data_out, v, m;
  logic        data_oe, io_request_n_out, io_request_oe, bus_request_n, interrupt_n;
  logic        priority_out, match_found, oe_d, sv_d1;
  wire logic   chip_enable_n, io_request_n, read_n, write_n, fetch_marker_n;
  wire logic   priority_in, bus_grant_n;
  wire logic [7:0] data_bus;
  logic [15:0] exp_data[$];
  logic [16:0] exp_srch[$];
  integer      seed;
  int          num_errors, checks_done;

  dfhi_host_interface DUT (
    .mclk(mclk), .nrst(nrst), .chip_enable_n(chip_enable_n), .io_request_n_in(io_request_n),
    .read_n(read_n), .write_n(write_n), .fetch_marker_n(fetch_marker_n),
    .priority_in(priority_in), .bus_grant_n(bus_grant_n), .data_in(data_bus),
    .engine_bus_req(engine_bus_req), .engine_io_cycle(engine_io_cycle), .irq_event(irq_event),
    .search_valid(search_valid), .search_word(search_word), .data_out(data_out),
    .data_oe(data_oe), .io_request_n_out(io_request_n_out), .io_request_oe(io_request_oe),
    .bus_request_n(bus_request_n), .interrupt_n(interrupt_n), .priority_out(priority_out),
    .address_out(address_out), .match_found(match_found));

  dfhi_host_model host (
    .mclk(mclk), .bus_request_n(bus_request_n), .data_out(data_out), .data_oe(data_oe),
    .io_req_n_out(io_request_n_out), .io_req_oe(io_request_oe), .chip_enable_n(chip_enable_n),
    .io_request_n(io_request_n), .read_n(read_n), .write_n(write_n),
    .fetch_marker_n(fetch_marker_n), .priority_in(priority_in), .bus_grant_n(bus_grant_n),
    .data_bus(data_bus));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    checks_done++;
    if ((got & msk) !== exp) begin
      num_errors++;
      $display("mismatch at %0t: byte %h expected %h", $time, got & msk, exp);
    end
  endtask : cmp_byte

  task automatic cmp_search(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: address/match %h expected %h", $time, got, exp);
    end
  endtask : cmp_search

  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] d);
    host.host_cycle(5'b00101, d, 4);
  endtask : wr
  task automatic status(input logic [7:0] x);
    exp_data.push_back({8'hF7, x});
    host.host_cycle(5'b00011, 8'h00, 6);
  endtask : status
  task automatic fetch(input logic [7:0] d);
    host.host_cycle(5'b11010, d, 3);
  endtask : fetch
  task automatic search(input logic [15:0] word, input logic hit);
    a = a + 16'h0001;
    exp_srch.push_back({a, hit});
    @(negedge mclk);
    {search_valid, search_word} = {1'b1, word};
    @(negedge mclk);
    search_valid = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : search
  task automatic irq();
    @(negedge mclk);
    irq_event = 1'b1;
    @(negedge mclk);
    irq_event = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : irq

  // oldest expectation taken when a result shows
  always @(posedge mclk) begin
    oe_d <= data_oe;
    sv_d1 <= search_valid;
    if (data_oe === 1'b1 && oe_d !== 1'b1) begin
      ed = (exp_data.size() == 0) ? 16'h0001 : exp_data.pop_front();
      cmp_byte(data_out, ed[7:0], ed[15:8]);
    end
    if (sv_d1 === 1'b1) begin
      cmp_search({address_out, match_found}, exp_srch.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    seed = 32'hAF74E361;
    {nrst, engine_bus_req, engine_io_cycle, irq_event, search_valid, oe_d, sv_d1} = 7'h00;
    search_word = 16'h0000;
    v = 8'($random(seed));
    m = 8'($random(seed));
    a = 16'($random(seed));
    repeat (4) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    cmp_byte({3'b000, data_oe, interrupt_n, bus_request_n, priority_out, io_request_oe},
             8'h0C, 8'hFF);
    cmp_search({address_out, match_found}, 17'h00000);
    engine_bus_req = 1'b1;
    repeat (8) @(negedge mclk);
    engine_io_cycle = 1'b1;
    repeat (4) @(negedge mclk);
    cmp_byte({4'h0, bus_request_n, bus_grant_n, io_request_oe, io_request_n}, 8'h02, 8'hFF);
    cmp_byte({4'h0, host.page_reg}, 8'h0A, 8'hFF);
    {engine_bus_req, engine_io_cycle} = 2'b00;
    repeat (6) @(negedge mclk);
    wr(dfhi_pkg::CMD_LOAD_MATCH);
    wr(m);
    wr(dfhi_pkg::CMD_LOAD_ADDRESS);
    wr(a[7:0]);
    wr(a[15:8]);
    wr(dfhi_pkg::CMD_LOAD_VECTOR);
    wr(v);
    status(8'h00);
    search({~m, m}, 1'b1);
    search({m, ~m}, 1'b0);
    wr(dfhi_pkg::CMD_LANE_UPPER);
    status(8'h10);
    search({m, ~m}, 1'b1);
    search({~m, m}, 1'b0);
    wr(dfhi_pkg::CMD_LANE_LOWER);
    irq();
    status(8'h00);
    wr(dfhi_pkg::CMD_ENABLE_INT);
    irq();
    cmp_byte({6'h00, interrupt_n, priority_out}, 8'h00, 8'hFF);
    status(8'h05);
    exp_data.push_back({8'hFF, v});
    host.host_cycle(5'b10110, 8'h00, 6);
    status(8'h06);
    fetch(dfhi_pkg::RETURN_BYTE0);
    fetch(8'h00);
    fetch(dfhi_pkg::RETURN_BYTE1);
    status(8'h06);
    fetch(dfhi_pkg::RETURN_BYTE0);
    fetch(dfhi_pkg::RETURN_BYTE1);
    status(8'h04);
    cmp_byte({6'h00, interrupt_n, priority_out}, 8'h03, 8'hFF);
    host.host_cycle(5'b10110, 8'h00, 6);
    irq();
    exp_data.push_back({8'hFF, v});
    host.host_cycle(5'b10110, 8'h00, 6);
    host.host_cycle(5'b11100, dfhi_pkg::RETURN_BYTE0, 3);
    host.host_cycle(5'b11100, dfhi_pkg::RETURN_BYTE1, 3);
    status(8'h04);
    irq();
    exp_data.push_back({8'hFF, v});
    host.host_cycle(5'b10110, 8'h00, 6);
    wr(dfhi_pkg::CMD_RESET_DISABLE_INT);
    status(8'h00);
    cmp_byte(8'(exp_data.size() + exp_srch.size()), 8'h00, 8'hFF);
    wrap_up();
  end
endmodule : test_dma_foreign_host_interface
`default_nettype wire
